// File: bus_hold_dma_port.sv
// processor bus strobes, timer and flag pins, bus hold and external dma
// assumes the core holds its fetch request until acked, and all pin
// inputs are already synchronous to core_clk
`timescale 1ns/1ns
module bus_hold_dma_port #(
  parameter int AW = dma_port_pkg::ADDR_W,
  parameter int DW = dma_port_pkg::DATA_W,
  parameter int WW = dma_port_pkg::WAIT_W,
  parameter int HALF_CYC = dma_port_pkg::HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic address_visibility_bit,
  input wire logic cpu_req,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic cpu_vector,
  input wire logic cpu_onchip,
  input wire logic [WW-1:0] cpu_waits,
  output logic cpu_ack,
  input wire logic timer_tick,
  input wire logic flag_level,
  output logic machine_clock_output,
  output logic fetch_strobe_n,
  output logic interrupt_ack_strobe_n,
  output logic timer_output_pulse,
  output logic external_flag_out,
  output logic [AW-1:0] addr_out,
  output logic addr_oe,
  input wire logic [AW-1:0] addr_in,
  output logic mem_ctrl_oe,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic [DW-1:0] data_in,
  input wire logic hold_req_n,
  output logic hold_grant_n,
  input wire logic external_bus_request_n,
  input wire logic external_access_strobe_n,
  input wire logic external_read_write,
  output logic [AW-1:0] dma_rd_addr,
  input wire logic [DW-1:0] dma_rd_data,
  output logic dma_wr_valid,
  input wire logic dma_wr_ready,
  output logic [AW-1:0] dma_wr_addr,
  output logic [DW-1:0] dma_wr_data
);
  localparam int HCW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  dma_port_pkg::bus_state_t state_r;
  dma_port_pkg::bus_state_t state_nxt;
  logic [HCW-1:0] div_r;
  logic mclk_r;
  logic half_tick;
  logic mclk_rise;
  logic mclk_fall;
  logic [3:0] half_cnt_r;
  logic [3:0] hold_cnt_r;
  logic [3:0] cyc_len_h;
  logic [3:0] timer_output_pulse_cnt_r;
  logic timer_output_pulse_pend_r;
  logic strobe_xs_r;
  logic held;
  logic xs_prev_r;
  logic wr_done;
  logic pend_valid_r;
  logic [AW+DW-1:0] pend_word_r;

  word_buf_if #(.W(AW + DW)) wbuf ();

  word_buf #(.W(AW + DW), .DEPTH(dma_port_pkg::BUF_DEPTH)) u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(wbuf.store)
  );

  // machine clock divider; each half period ends on half_tick
  assign half_tick = (div_r == HCW'(HALF_CYC - 1));
  assign mclk_rise = half_tick && !mclk_r;
  assign mclk_fall = half_tick && mclk_r;
  assign machine_clock_output = mclk_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_r <= '0;
      mclk_r <= 1'b0;
    end else if (half_tick) begin
      div_r <= '0;
      mclk_r <= !mclk_r;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // own cycle length in halves: one machine cycle plus the waits
  assign cyc_len_h = 4'((32'(cpu_waits) + 1) * 2);
  assign held = (state_r != dma_port_pkg::ST_IDLE) &&
    (state_r != dma_port_pkg::ST_CYCLE);

  // next bus state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dma_port_pkg::ST_IDLE: begin
        if (!hold_req_n) begin
          if (half_tick && hold_cnt_r >= dma_port_pkg::HOLD_FLOAT_H) begin
            state_nxt = dma_port_pkg::ST_FLOAT;
          end
        end else if (cpu_req && mclk_rise) begin
          state_nxt = dma_port_pkg::ST_CYCLE;
        end
      end
      dma_port_pkg::ST_CYCLE: begin
        if (half_tick && half_cnt_r == cyc_len_h - 4'h1) begin
          state_nxt = dma_port_pkg::ST_IDLE;
        end
      end
      dma_port_pkg::ST_FLOAT: begin
        if (half_tick) begin
          state_nxt = dma_port_pkg::ST_HELD;
        end
      end
      dma_port_pkg::ST_HELD: begin
        if (hold_req_n) begin
          state_nxt = dma_port_pkg::ST_UNHOLD;
        end else if (!external_bus_request_n) begin
          state_nxt = dma_port_pkg::ST_DMA_WAIT;
        end
      end
      dma_port_pkg::ST_DMA_WAIT: begin
        // grant in four to six halves
        if (external_bus_request_n) begin
          state_nxt = dma_port_pkg::ST_HELD;
        end else if (half_tick && half_cnt_r == dma_port_pkg::XBR_GRANT_H) begin
          state_nxt = dma_port_pkg::ST_DMA;
        end
      end
      dma_port_pkg::ST_DMA: begin
        if (external_bus_request_n) begin
          state_nxt = dma_port_pkg::ST_DMA_END;
        end
      end
      dma_port_pkg::ST_DMA_END: begin
        // release in two to four halves
        if (half_tick && half_cnt_r == dma_port_pkg::XBR_RELEASE_H) begin
          state_nxt = dma_port_pkg::ST_HELD;
        end
      end
      dma_port_pkg::ST_UNHOLD: begin
        if (half_tick && half_cnt_r == dma_port_pkg::HOLD_RELEASE_H) begin
          state_nxt = dma_port_pkg::ST_IDLE;
        end
      end
      default: state_nxt = dma_port_pkg::ST_IDLE;
    endcase
  end

  // state register and halves spent in the current state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= dma_port_pkg::ST_IDLE;
      half_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        half_cnt_r <= '0;
      end else if (half_tick && half_cnt_r != dma_port_pkg::CNT_MAX) begin
        half_cnt_r <= half_cnt_r + 4'h1;
      end
    end
  end

  // halves since the hold request fell; saturates, cleared on release
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_cnt_r <= '0;
    end else if (hold_req_n) begin
      hold_cnt_r <= '0;
    end else if (half_tick && hold_cnt_r != dma_port_pkg::CNT_MAX) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end

  // hold grant and pin enables
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_grant_n <= 1'b1;
      addr_oe <= 1'b1;
      mem_ctrl_oe <= 1'b1;
    end else begin
      hold_grant_n <= (state_nxt == dma_port_pkg::ST_IDLE) ||
        (state_nxt == dma_port_pkg::ST_CYCLE) ||
        (state_nxt == dma_port_pkg::ST_FLOAT);
      addr_oe <= (state_nxt == dma_port_pkg::ST_IDLE) ||
        (state_nxt == dma_port_pkg::ST_CYCLE);
      mem_ctrl_oe <= (state_nxt == dma_port_pkg::ST_IDLE) ||
        (state_nxt == dma_port_pkg::ST_CYCLE);
    end
  end

  // own fetch: strobes, address and completion
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strobe_xs_r <= 1'b0;
      interrupt_ack_strobe_n <= 1'b1;
      addr_out <= '0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= (state_r == dma_port_pkg::ST_CYCLE) &&
        (state_nxt == dma_port_pkg::ST_IDLE);
      if (state_r == dma_port_pkg::ST_IDLE &&
          state_nxt == dma_port_pkg::ST_CYCLE) begin
        strobe_xs_r <= !cpu_vector;
        interrupt_ack_strobe_n <= !cpu_vector;
        // hidden on-chip fetch keeps old address
        // vector id rides on bits 4..1
        if (!(cpu_onchip && address_visibility_bit)) begin
          addr_out <= cpu_addr;
        end
      end else if (state_r != dma_port_pkg::ST_CYCLE ||
          (half_tick && half_cnt_r == dma_port_pkg::STROBE_LOW_H - 4'h1)) begin
        strobe_xs_r <= 1'b0;
        interrupt_ack_strobe_n <= 1'b1;
      end
    end
  end

  // fetch strobe is the own fetch strobe or, under hold, the dma grant
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fetch_strobe_n <= 1'b1;
    end else if (held) begin
      fetch_strobe_n <= !((state_nxt == dma_port_pkg::ST_DMA) ||
        (state_nxt == dma_port_pkg::ST_DMA_END));
    end else if (state_r == dma_port_pkg::ST_IDLE &&
        state_nxt == dma_port_pkg::ST_CYCLE) begin
      fetch_strobe_n <= cpu_vector;
    end else if (!strobe_xs_r || (half_tick &&
        half_cnt_r == dma_port_pkg::STROBE_LOW_H - 4'h1)) begin
      fetch_strobe_n <= 1'b1;
    end
  end

  // dma read path; data follows the master's address each cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dma_rd_addr <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      dma_rd_addr <= addr_in;
      data_out <= dma_rd_data;
      data_oe <= ((state_nxt == dma_port_pkg::ST_DMA) ||
        (state_nxt == dma_port_pkg::ST_DMA_END)) && external_read_write;
    end
  end

  // write capture at the end of the master's access strobe;
  // a second write before the pending word enters the buffer
  // overwrites it, so the master must keep strobes apart
  assign wr_done = !xs_prev_r && external_access_strobe_n &&
    !external_read_write && !fetch_strobe_n && held;
  assign wbuf.in_valid = pend_valid_r;
  assign wbuf.in_data = pend_word_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xs_prev_r <= 1'b1;
      pend_valid_r <= 1'b0;
      pend_word_r <= '0;
    end else begin
      xs_prev_r <= external_access_strobe_n;
      if (wr_done) begin
        pend_valid_r <= 1'b1;
        pend_word_r <= {addr_in, data_in};
      end else if (wbuf.in_ready) begin
        pend_valid_r <= 1'b0;
      end
    end
  end

  // buffer drains to the core side, which may stall
  assign wbuf.out_ready = dma_wr_ready;
  assign dma_wr_valid = wbuf.out_valid;
  assign dma_wr_addr = wbuf.out_data[AW+DW-1:DW];
  assign dma_wr_data = wbuf.out_data[DW-1:0];

  // timer pulse starts on a falling machine clock edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      timer_output_pulse_pend_r <= 1'b0;
      timer_output_pulse_cnt_r <= '0;
      timer_output_pulse <= 1'b0;
    end else begin
      // two halves from a fall
      // a tick on the starting fall is used up by that start, so the
      // pending bit must clear then or a second pulse would follow
      if (mclk_fall && !timer_output_pulse) begin
        timer_output_pulse_pend_r <= 1'b0;
      end else if (timer_tick) begin
        timer_output_pulse_pend_r <= 1'b1;
      end
      if (mclk_fall && !timer_output_pulse && (timer_output_pulse_pend_r || timer_tick)) begin
        timer_output_pulse <= 1'b1;
        timer_output_pulse_cnt_r <= '0;
      end else if (timer_output_pulse && half_tick) begin
        if (timer_output_pulse_cnt_r == dma_port_pkg::TIMER_OUTPUT_PULSE_HIGH_H - 4'h1) begin
          timer_output_pulse <= 1'b0;
        end
        timer_output_pulse_cnt_r <= timer_output_pulse_cnt_r + 4'h1;
      end
    end
  end

  // flag pin changes only on a rising machine clock edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      external_flag_out <= 1'b0;
    end else if (mclk_rise) begin
      external_flag_out <= flag_level;
    end
  end
endmodule : bus_hold_dma_port

// File: dma_port_pkg.sv
// constants, states and timing counts of the bus hold and dma port
// assumes a 100 mhz core clock; the machine clock is divided from it
package dma_port_pkg;
  localparam int CORE_PERIOD_NS = 10;
  // half period of the machine clock output, in ns
  localparam int MCLK_HALF_NS = 20;
  localparam int HALF_CYC = (MCLK_HALF_NS + CORE_PERIOD_NS - 1) /
    CORE_PERIOD_NS;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 3;
  // delays in half periods of the machine clock
  localparam logic [3:0] HOLD_FLOAT_H = 4'h4;
  localparam logic [3:0] HOLD_RELEASE_H = 4'h2;
  localparam logic [3:0] XBR_GRANT_H = 4'h4;
  localparam logic [3:0] XBR_RELEASE_H = 4'h2;
  localparam logic [3:0] STROBE_LOW_H = 4'h2;
  localparam logic [3:0] TIMER_OUTPUT_PULSE_HIGH_H = 4'h2;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CYCLE = 3'b001,
    ST_FLOAT = 3'b010,
    ST_HELD = 3'b011,
    ST_DMA_WAIT = 3'b100,
    ST_DMA = 3'b101,
    ST_DMA_END = 3'b110,
    ST_UNHOLD = 3'b111
  } bus_state_t;
endpackage : dma_port_pkg

// File: word_buf_if.sv
// valid/ready carrier between the port and its write buffer
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface word_buf_if #(parameter int W = 32);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
    input out_valid, input out_data, output out_ready);
endinterface : word_buf_if

// File: word_buf.sv
// small shifting buffer of flip-flop entries, head always at entry 0
// assumes the user side honours in_ready and out_valid
`timescale 1ns/1ns
module word_buf #(
  parameter int W = 32,
  parameter int DEPTH = dma_port_pkg::BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  word_buf_if.store bus
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] ent_r [DEPTH];
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [CW-1:0] wr_idx;
  logic push;
  logic pop;
  logic valid_r;

  // handshakes and write slot
  assign bus.in_ready = (count_r != CW'(DEPTH));
  assign push = bus.in_valid && bus.in_ready;
  assign pop = valid_r && bus.out_ready;
  assign wr_idx = pop ? count_r - 1'b1 : count_r;
  assign count_nxt = count_r + CW'(push) - CW'(pop);
  assign bus.out_valid = valid_r;
  assign bus.out_data = ent_r[0];

  // fill level and registered valid
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_r <= '0;
      valid_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      valid_r <= (count_nxt != '0);
    end
  end

  // entries shift toward the head on each pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        ent_r[i] <= '0;
      end else if (push && wr_idx == CW'(i)) begin
        ent_r[i] <= bus.in_data;
      end else if (pop) begin
        if (i + 1 < DEPTH) begin
          ent_r[i] <= ent_r[(i + 1 < DEPTH) ? i + 1 : i];
        end
      end
    end
  end
endmodule : word_buf

// File: bus_hold_dma_port_properties.sv
// assertions on the top ports of the bus hold and dma port
// assumes HALF_CYC of 2: one machine half period is two core cycles
`timescale 1ns/1ns
module bus_hold_dma_port_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cpu_ack,
  input wire logic fetch_strobe_n,
  input wire logic addr_oe,
  input wire logic mem_ctrl_oe,
  input wire logic data_oe,
  input wire logic hold_req_n,
  input wire logic hold_grant_n,
  input wire logic external_bus_request_n,
  input wire logic external_read_write
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic busy_r;

  // own fetch runs from its strobe to its ack; a hold must wait for it
  always_ff @(posedge core_clk) begin
    if (!rstn || cpu_ack) begin
      busy_r <= 1'b0;
    end else if (!fetch_strobe_n && hold_grant_n) begin
      busy_r <= 1'b1;
    end
  end

  a_fetch_width: assert property (
    $fell(fetch_strobe_n) && hold_grant_n |->
      !fetch_strobe_n [*4] ##1 fetch_strobe_n)
    else $error("fetch strobe width");
  a_hold_waits: assert property (
    busy_r |-> hold_grant_n) else $error("hold mid cycle");
  a_hold_delay: assert property (
    $fell(hold_req_n) && hold_grant_n |-> hold_grant_n [*8])
    else $error("hold grant early");
  a_float_first: assert property (
    $fell(hold_grant_n) |-> !addr_oe && !mem_ctrl_oe && !$past(addr_oe))
    else $error("bus not floated");
  a_dma_grant: assert property (
    $fell(external_bus_request_n) && !hold_grant_n |->
      fetch_strobe_n [*8] ##[1:5] !fetch_strobe_n)
    else $error("access grant window");
  a_dma_end: assert property (
    $rose(external_bus_request_n) && !fetch_strobe_n && !hold_grant_n |->
      !fetch_strobe_n [*4] ##[1:5] fetch_strobe_n)
    else $error("access end window");
  a_read_drive: assert property (
    !fetch_strobe_n && !hold_grant_n && external_read_write |->
      ##[0:4] data_oe) else $error("read data not driven");
  a_write_float: assert property (
    !external_read_write && !hold_grant_n |=> !data_oe)
    else $error("data driven in write");
  a_grant_float: assert property (
    $rose(fetch_strobe_n) && !hold_grant_n |-> ##[0:2] !data_oe)
    else $error("data not floated");
endmodule : bus_hold_dma_port_chk

bind bus_hold_dma_port bus_hold_dma_port_chk chk_i (.core_clk(core_clk),
  .rstn(rstn), .cpu_ack(cpu_ack), .fetch_strobe_n(fetch_strobe_n),
  .addr_oe(addr_oe), .mem_ctrl_oe(mem_ctrl_oe), .data_oe(data_oe),
  .hold_req_n(hold_req_n), .hold_grant_n(hold_grant_n),
  .external_bus_request_n(external_bus_request_n),
  .external_read_write(external_read_write));

// File: dma_master_model.sv
// model of the external dma master on hold, request and strobe pins
// assumes the bench resolves the shared address and data wires
`timescale 1ns/1ns
module dma_master_model (
  input wire logic core_clk,
  input wire logic hold_grant_n,
  input wire logic fetch_strobe_n,
  input wire logic [15:0] data_bus,
  output logic hold_req_n,
  output logic external_bus_request_n,
  output logic external_access_strobe_n,
  output logic external_read_write,
  output logic [15:0] m_addr,
  output logic [15:0] m_data
);
  // pulled-up lines rest high
  initial begin
    hold_req_n = 1'b1;
    external_bus_request_n = 1'b1;
    external_access_strobe_n = 1'b1;
    external_read_write = 1'b1;
    m_addr = 16'h0;
    m_data = 16'h0;
  end

  // sel 0 moves the hold request, sel 1 the bus request, then waits
  task automatic req(input int sel, input logic lvl, output int lat);
    lat = 0;
    while (sel == 1 && hold_grant_n !== 1'b0) @(posedge core_clk);
    @(posedge core_clk);
    if (sel == 0) hold_req_n <= lvl;
    else external_bus_request_n <= lvl;
    do begin
      @(posedge core_clk);
      lat++;
    end while ((sel == 0 ? hold_grant_n : fetch_strobe_n) !== lvl &&
      lat < 40);
  endtask : req

  // one strobed access; released lines go high or show inverted data
  task automatic access(input logic rd, input logic [15:0] a,
      input logic [15:0] d, input int slow, output logic [15:0] q);
    while (fetch_strobe_n !== 1'b0) @(posedge core_clk);
    @(posedge core_clk);
    external_read_write <= rd;
    m_addr <= a;
    m_data <= d;
    repeat (2 + slow) @(posedge core_clk);
    external_access_strobe_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    q = data_bus;
    external_access_strobe_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    external_read_write <= 1'b1;
    m_addr <= ~a;
    m_data <= ~d;
    repeat (3) @(posedge core_clk);
  endtask : access
endmodule : dma_master_model

// File: bus_hold_dma_port_tb_top.sv
// self-checking bench of the bus hold and dma port
// assumes the checker binds itself; the master model drives x lines
`timescale 1ns/1ns
module bus_hold_dma_port_tb_top;
  logic core_clk, rstn, address_visibility_bit, cpu_req, cpu_vector;
  logic cpu_onchip, cpu_ack, timer_tick, flag_level, machine_clock_output;
  logic fetch_strobe_n, interrupt_ack_strobe_n, timer_output_pulse;
  logic external_flag_out, addr_oe, mem_ctrl_oe, data_oe, hold_req_n;
  logic hold_grant_n, external_bus_request_n, external_access_strobe_n;
  logic external_read_write, dma_wr_valid, dma_wr_ready;
  logic [2:0] cpu_waits;
  logic [15:0] cpu_addr, addr_out, addr_in, data_out, data_in, m_addr;
  logic [15:0] m_data, dma_rd_addr, dma_rd_data, dma_wr_addr, dma_wr_data;
  logic [31:0] got_q[$];
  int err_total, n_checks, cyc;

  // pins: whoever enables drives; memory answers a fixed pattern
  assign addr_in = addr_oe ? addr_out : m_addr;
  assign data_in = data_oe ? data_out : m_data;
  assign dma_rd_data = dma_rd_addr ^ 16'h5a5a;

  bus_hold_dma_port dut (.core_clk(core_clk), .rstn(rstn),
    .address_visibility_bit(address_visibility_bit), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_vector(cpu_vector), .cpu_onchip(cpu_onchip),
    .cpu_waits(cpu_waits), .cpu_ack(cpu_ack), .timer_tick(timer_tick),
    .flag_level(flag_level), .machine_clock_output(machine_clock_output),
    .fetch_strobe_n(fetch_strobe_n),
    .interrupt_ack_strobe_n(interrupt_ack_strobe_n),
    .timer_output_pulse(timer_output_pulse),
    .external_flag_out(external_flag_out), .addr_out(addr_out),
    .addr_oe(addr_oe), .addr_in(addr_in), .mem_ctrl_oe(mem_ctrl_oe),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .hold_req_n(hold_req_n), .hold_grant_n(hold_grant_n),
    .external_bus_request_n(external_bus_request_n),
    .external_access_strobe_n(external_access_strobe_n),
    .external_read_write(external_read_write), .dma_rd_addr(dma_rd_addr),
    .dma_rd_data(dma_rd_data), .dma_wr_valid(dma_wr_valid),
    .dma_wr_ready(dma_wr_ready), .dma_wr_addr(dma_wr_addr),
    .dma_wr_data(dma_wr_data));

  dma_master_model master (.core_clk(core_clk), .hold_grant_n(hold_grant_n),
    .fetch_strobe_n(fetch_strobe_n), .data_bus(data_in),
    .hold_req_n(hold_req_n), .external_bus_request_n(external_bus_request_n),
    .external_access_strobe_n(external_access_strobe_n),
    .external_read_write(external_read_write), .m_addr(m_addr),
    .m_data(m_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // drained words; ready low stands for a stalling memory
  always @(posedge core_clk) begin
    if (rstn && dma_wr_valid && dma_wr_ready) begin
      got_q.push_back({dma_wr_addr, dma_wr_data});
    end
  end

  // hang guard, far above the cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // one own fetch; counts strobe cycles until the ack pulse
  task automatic fetch(input logic vec, input logic onch,
      input logic [2:0] w, input logic [15:0] a);
    int n, low;
    logic [15:0] old;
    old = addr_out;
    n = 0;
    low = 0;
    @(posedge core_clk);
    cpu_req <= 1'b1;
    cpu_vector <= vec;
    cpu_onchip <= onch;
    cpu_waits <= w;
    cpu_addr <= a;
    do begin
      @(posedge core_clk);
      n++;
      if ((vec ? interrupt_ack_strobe_n : fetch_strobe_n) === 1'b0) low++;
    end while (cpu_ack !== 1'b1 && n < 100);
    cpu_req <= 1'b0;
    chk("strobe cycles", 16'h4, 16'(low));
    chk("fetch addr", (onch && address_visibility_bit) ? old : a,
      addr_out);
    chk("vector id", {12'h0, a[4:1]}, {12'h0, addr_out[4:1]});
  endtask : fetch

  task automatic t_fetches();
    logic [15:0] a [5] = '{16'h1234, 16'h2345, 16'h0016, 16'h3456, 16'h001e};
    logic [2:0] w [5] = '{3'h0, 3'h3, 3'h2, 3'h0, 3'h1};
    logic [2:0] m [5] = '{3'h0, 3'h0, 3'h2, 3'h5, 3'h3};
    for (int i = 0; i < 5; i++) begin
      address_visibility_bit <= m[i][2];
      fetch(m[i][1], m[i][0], w[i], a[i]);
    end
    $display("test fetches done, mismatches %0d", err_total);
  endtask : t_fetches

  task automatic t_timer_flag();
    int wid, hi;
    logic pm;
    logic [1:0] at_fall;
    wid = 0;
    hi = 0;
    at_fall = 2'h0;
    @(posedge core_clk);
    timer_tick <= 1'b1;
    flag_level <= 1'b1;
    @(posedge core_clk);
    timer_tick <= 1'b0;
    pm = machine_clock_output;
    // clock level before and at the first high sample of the pulse
    repeat (16) begin
      @(posedge core_clk);
      if (timer_output_pulse === 1'b1 && wid == 0) begin
        at_fall = {pm, machine_clock_output};
      end
      if (timer_output_pulse === 1'b1) wid++;
      if (machine_clock_output === 1'b1) hi++;
      pm = machine_clock_output;
    end
    chk("timer width", 16'h4, 16'(wid));
    chk("timer on fall", 16'h2, {14'h0, at_fall});
    chk("machine clock high", 16'h8, 16'(hi));
    chk("flag out", 16'h1, {15'h0, external_flag_out});
    $display("test timer and flag done, mismatches %0d", err_total);
  endtask : t_timer_flag

  task automatic t_hold();
    int lat, hits;
    hits = 0;
    fork
      fetch(1'b0, 1'b0, 3'h3, 16'h4321);
      begin
        wait (fetch_strobe_n === 1'b0);
        @(posedge core_clk);
        master.req(0, 1'b0, lat);
      end
    join
    chk("hold delay", 16'h1, {15'h0, lat >= 14 && lat < 40});
    chk("bus floated", 16'h0, {14'h0, addr_oe, mem_ctrl_oe});
    cpu_req <= 1'b1;
    repeat (16) begin
      @(posedge core_clk);
      if (fetch_strobe_n !== 1'b1 || cpu_ack !== 1'b0) hits++;
    end
    cpu_req <= 1'b0;
    chk("own cycle in hold", 16'h0, 16'(hits));
    master.req(0, 1'b1, lat);
    chk("release delay", 16'h1, {15'h0, lat >= 5 && lat < 40});
    chk("addr driven", 16'h1, {15'h0, addr_oe});
    $display("test hold done, mismatches %0d", err_total);
  endtask : t_hold

  task automatic t_dma();
    int lat;
    logic [15:0] q;
    master.req(0, 1'b0, lat);
    master.req(1, 1'b0, lat);
    chk("grant delay", 16'h1, {15'h0, lat >= 9 && lat <= 13});
    master.access(1'b1, 16'h0123, 16'hffff, 0, q);
    chk("read data", 16'h0123 ^ 16'h5a5a, q);
    dma_wr_ready <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      master.access(1'b0, 16'h0a01 + 16'(i), 16'hd001 + 16'(i), 2 - i, q);
    end
    chk("stall valid", 16'h1, {15'h0, dma_wr_valid});
    chk("none drained", 16'h0, 16'(got_q.size()));
    dma_wr_ready <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("words out", 16'h3, 16'(got_q.size()));
    for (int i = 0; i < 3; i++) begin
      chk("write addr", 16'h0a01 + 16'(i), got_q[i][31:16]);
      chk("write data", 16'hd001 + 16'(i), got_q[i][15:0]);
    end
    master.req(1, 1'b1, lat);
    chk("grant end", 16'h1, {15'h0, lat >= 5 && lat <= 9});
    repeat (2) @(posedge core_clk);
    chk("data floated", 16'h0, {15'h0, data_oe});
    master.req(0, 1'b1, lat);
    $display("test dma done, mismatches %0d", err_total);
  endtask : t_dma

  initial begin
    rstn = 1'b0;
    address_visibility_bit = 1'b0;
    cpu_req = 1'b0;
    cpu_vector = 1'b0;
    cpu_onchip = 1'b0;
    cpu_waits = 3'h0;
    cpu_addr = 16'h0;
    timer_tick = 1'b0;
    flag_level = 1'b0;
    dma_wr_ready = 1'b1;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_fetches();
    t_timer_flag();
    t_hold();
    t_dma();
    summarize();
  end
endmodule : bus_hold_dma_port_tb_top
